// file: inc/can_tx_buffer_pkg.sv
// Constants, types and field layout of the CAN transmit buffer set
//
// Operation
// - Completion flag set after send, modes 1-2
// - Abort of pending message sets aborted flag
// - Lost arbitration sets lost-arbitration flag
// - Bus error during send sets error flag
// - Request queues buffer, clears three status flags
// - Successful send clears request bit itself
// - Buffer registers read-only while request set
// - Clearing pending request aborts, reports aborted
// - Priority field 11 highest, 00 lowest
// - Priority orders sending, never alters identifier
// - Id high byte: id 10:3 or 28:21
// - Id low top bits: id 2:0 or 20:18
// - Extended select one sends 29-bit identifier
// - Extended select zero ignores low eighteen bits
// - Extended bits 17:0 in three further fields
// - Unimplemented bits always read as zero
// - Three buffers, eight data bytes each
// - Mode 0 reads completion bit as zero
// - Two-bit mode select, 11 reserved
// - Length code 0-8 bytes, above reserved
package can_tx_buffer_pkg;

    localparam int NUM_BUFFERS = 3;
    localparam int NUM_DATA    = 8;

    // Register map, byte addresses; buffer n sits at n * BUF_STRIDE
    localparam logic [7:0] BUF_STRIDE   = 8'h40;
    localparam logic [5:0] OFS_CONTROL  = 6'h00;
    localparam logic [5:0] OFS_SID_HIGH = 6'h04;
    localparam logic [5:0] OFS_SID_LOW  = 6'h08;
    localparam logic [5:0] OFS_EID_HIGH = 6'h0C;
    localparam logic [5:0] OFS_EID_LOW  = 6'h10;
    localparam logic [5:0] OFS_LENGTH   = 6'h14;
    localparam logic [5:0] OFS_DATA     = 6'h20;
    localparam logic [7:0] OFS_MODE     = 8'hC0;
    localparam logic [7:0] OFS_STATUS   = 8'hC4;

    // Control byte fields
    localparam int CTL_SENT_BIT = 7;
    localparam int CTL_ABT_BIT  = 6;
    localparam int CTL_LARB_BIT = 5;
    localparam int CTL_ERR_BIT  = 4;
    localparam int CTL_REQ_BIT  = 3;
    localparam int CTL_PRI_LSB  = 0;

    // Identifier low byte: implemented bits 7-5, 3, 1-0
    localparam logic [7:0] SIDL_IMPL_MASK = 8'hEB;
    localparam int         SIDL_EXT_BIT   = 3;

    // Status register fields
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_ACTIVE_LSB = 4;
    localparam int STAT_REQ_LSB    = 8;

    // Operating modes
    localparam logic [1:0] MODE_LEGACY     = 2'h0;
    localparam logic [1:0] MODE_ENH_LEGACY = 2'h1;
    localparam logic [1:0] MODE_ENH_FIFO   = 2'h2;
    localparam logic [1:0] MODE_RESERVED   = 2'h3;
    localparam logic [1:0] MODE_RESET      = MODE_LEGACY;

    localparam logic [3:0] MAX_BYTES = 4'h8;

    typedef enum logic [3:0] {
        RK_NONE, RK_CONTROL, RK_SID_HIGH, RK_SID_LOW, RK_EID_HIGH,
        RK_EID_LOW, RK_LENGTH, RK_DATA, RK_MODE, RK_STATUS
    } reg_kind_t;

    typedef struct packed {
        reg_kind_t  kind;
        logic [1:0] buf_idx;
        logic [2:0] byte_idx;
    } addr_dec_t;

    // Frame offered to the bit engine
    typedef struct packed {
        logic        extended;
        logic [28:0] ident;
        logic [3:0]  byte_count;
        logic [63:0] payload;
        logic [1:0]  buf_idx;
    } frame_t;

    // Outcome pulses from the bit engine for the frame in flight
    typedef struct packed {
        logic done;
        logic lost_arb;
        logic bus_err;
        logic abort_ack;
    } tx_event_t;

endpackage : can_tx_buffer_pkg

// file: design/can_transmit_buffer_set.sv
// Three CAN transmit buffers with APB register access and priority scheduler
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none

module can_transmit_buffer_set import can_tx_buffer_pkg::*; (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Bit engine side
    output logic             frame_valid,
    input  wire logic        frame_ready,
    output frame_t           frame,
    output logic             abort_req,
    input  wire tx_event_t   tx_event
);

    typedef enum logic [1:0] {ST_IDLE, ST_OFFER, ST_SEND} state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Storage

    logic [NUM_BUFFERS-1:0] req_reg;
    logic [NUM_BUFFERS-1:0] sent_reg;
    logic [NUM_BUFFERS-1:0] abt_reg;
    logic [NUM_BUFFERS-1:0] larb_reg;
    logic [NUM_BUFFERS-1:0] err_reg;
    logic [NUM_BUFFERS-1:0] abort_pend_reg;
    logic [1:0]             prio_reg   [NUM_BUFFERS];
    logic [7:0]             sidh_reg   [NUM_BUFFERS];
    logic [7:0]             sidl_reg   [NUM_BUFFERS];
    logic [7:0]             eidh_reg   [NUM_BUFFERS];
    logic [7:0]             eidl_reg   [NUM_BUFFERS];
    logic [3:0]             len_reg    [NUM_BUFFERS];
    logic [7:0]             data_reg   [NUM_BUFFERS][NUM_DATA];
    logic [1:0]             mode_reg;
    state_t                 state_reg;
    logic [1:0]             active_reg;
    frame_t                 frame_reg;
    logic [31:0]            prdata_reg;
    logic                   pslverr_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Address decoding

    function automatic addr_dec_t decode(input logic [7:0] a);
        addr_dec_t d;
        logic [5:0] ofs;
        d = '{kind: RK_NONE, buf_idx: a[7:6], byte_idx: a[4:2]};
        ofs = a[5:0];
        if (a[1:0] != 2'h0) begin
            d.kind = RK_NONE;
        end else if (a == OFS_MODE) begin
            d.kind = RK_MODE;
        end else if (a == OFS_STATUS) begin
            d.kind = RK_STATUS;
        end else if (a >= 8'(NUM_BUFFERS) * BUF_STRIDE) begin
            d.kind = RK_NONE;
        end else if (ofs == OFS_CONTROL) begin
            d.kind = RK_CONTROL;
        end else if (ofs == OFS_SID_HIGH) begin
            d.kind = RK_SID_HIGH;
        end else if (ofs == OFS_SID_LOW) begin
            d.kind = RK_SID_LOW;
        end else if (ofs == OFS_EID_HIGH) begin
            d.kind = RK_EID_HIGH;
        end else if (ofs == OFS_EID_LOW) begin
            d.kind = RK_EID_LOW;
        end else if (ofs == OFS_LENGTH) begin
            d.kind = RK_LENGTH;
        end else if (ofs >= OFS_DATA) begin
            d.kind = RK_DATA;
        end
        return d;
    endfunction : decode

    addr_dec_t dec;
    logic      wr_en;
    logic      setup;

    assign dec   = decode(paddr);
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && (dec.kind != RK_NONE);

    // Zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Read path, captured in the setup cycle

    logic [7:0]  ctl_byte;
    logic [31:0] rd_word;

    always_comb begin
        ctl_byte = 8'h00;
        ctl_byte[CTL_SENT_BIT] = (mode_reg == MODE_LEGACY) ? 1'b0 : sent_reg[dec.buf_idx];
        ctl_byte[CTL_ABT_BIT]  = abt_reg[dec.buf_idx];
        ctl_byte[CTL_LARB_BIT] = larb_reg[dec.buf_idx];
        ctl_byte[CTL_ERR_BIT]  = err_reg[dec.buf_idx];
        ctl_byte[CTL_REQ_BIT]  = req_reg[dec.buf_idx];
        ctl_byte[CTL_PRI_LSB +: 2] = prio_reg[dec.buf_idx];
        rd_word = 32'h0000_0000;
        case (dec.kind)
            RK_CONTROL:  rd_word[7:0] = ctl_byte;
            RK_SID_HIGH: rd_word[7:0] = sidh_reg[dec.buf_idx];
            RK_SID_LOW:  rd_word[7:0] = sidl_reg[dec.buf_idx] & SIDL_IMPL_MASK;
            RK_EID_HIGH: rd_word[7:0] = eidh_reg[dec.buf_idx];
            RK_EID_LOW:  rd_word[7:0] = eidl_reg[dec.buf_idx];
            RK_LENGTH:   rd_word[3:0] = len_reg[dec.buf_idx];
            RK_DATA:     rd_word[7:0] = data_reg[dec.buf_idx][dec.byte_idx];
            RK_MODE:     rd_word[1:0] = mode_reg;
            RK_STATUS: begin
                rd_word[STAT_BUSY_BIT]        = (state_reg != ST_IDLE);
                rd_word[STAT_ACTIVE_LSB +: 2] = active_reg;
                rd_word[STAT_REQ_LSB +: 3]    = req_reg;
            end
            default:     rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            prdata_reg  <= pwrite ? 32'h0000_0000 : rd_word;
            pslverr_reg <= (dec.kind == RK_NONE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operating mode

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_reg <= MODE_RESET;
        end else if (wr_en && dec.kind == RK_MODE && pwdata[1:0] != MODE_RESERVED) begin
            mode_reg <= pwdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Identifier, length and payload bytes; contents not reset

    logic buf_open;
    assign buf_open = wr_en && !req_reg[dec.buf_idx];

    always_ff @(posedge clk) begin
        if (buf_open) begin
            case (dec.kind)
                RK_SID_HIGH: sidh_reg[dec.buf_idx] <= pwdata[7:0];
                RK_SID_LOW:  sidl_reg[dec.buf_idx] <= pwdata[7:0] & SIDL_IMPL_MASK;
                RK_EID_HIGH: eidh_reg[dec.buf_idx] <= pwdata[7:0];
                RK_EID_LOW:  eidl_reg[dec.buf_idx] <= pwdata[7:0];
                RK_LENGTH:   len_reg[dec.buf_idx]  <= pwdata[3:0];
                RK_DATA:     data_reg[dec.buf_idx][dec.byte_idx] <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-buffer control byte

    logic in_send;
    assign in_send = (state_reg == ST_SEND);

    for (genvar i = 0; i < NUM_BUFFERS; i++) begin : g_ctl
        logic own_send;
        logic ctl_wr;
        logic end_abort;
        assign own_send  = in_send && (active_reg == 2'(i));
        assign ctl_wr    = wr_en && (dec.kind == RK_CONTROL) && (dec.buf_idx == 2'(i));
        assign end_abort = own_send && abort_pend_reg[i]
                           && (tx_event.abort_ack || tx_event.lost_arb || tx_event.bus_err);

        always_ff @(posedge clk) begin
            if (sys_rst) begin
                req_reg[i]        <= 1'b0;
                sent_reg[i]       <= 1'b0;
                abt_reg[i]        <= 1'b0;
                larb_reg[i]       <= 1'b0;
                err_reg[i]        <= 1'b0;
                abort_pend_reg[i] <= 1'b0;
                prio_reg[i]       <= 2'h0;
            end else begin
                // Software side first so hardware events below win
                if (ctl_wr && !req_reg[i]) begin
                    req_reg[i]  <= pwdata[CTL_REQ_BIT];
                    prio_reg[i] <= pwdata[CTL_PRI_LSB +: 2];
                    if (pwdata[CTL_REQ_BIT]) begin
                        abt_reg[i]  <= 1'b0;
                        larb_reg[i] <= 1'b0;
                        err_reg[i]  <= 1'b0;
                    end
                    if (!pwdata[CTL_SENT_BIT]) begin
                        sent_reg[i] <= 1'b0;
                    end
                end else if (ctl_wr && !pwdata[CTL_REQ_BIT]) begin
                    // Abort: in flight waits for the engine, else at once
                    // Event in the same cycle ends the attempt now, or a pend would never clear
                    if (own_send && tx_event == '0) begin
                        abort_pend_reg[i] <= 1'b1;
                    end else if (!(own_send && tx_event.done)) begin
                        req_reg[i] <= 1'b0;
                        abt_reg[i] <= 1'b1;
                    end
                end
                if (own_send && tx_event.lost_arb) begin
                    larb_reg[i] <= 1'b1;
                end
                if (own_send && tx_event.bus_err) begin
                    err_reg[i] <= 1'b1;
                end
                if (end_abort && !tx_event.done) begin
                    req_reg[i]        <= 1'b0;
                    abt_reg[i]        <= 1'b1;
                    abort_pend_reg[i] <= 1'b0;
                end
                if (own_send && tx_event.done) begin
                    req_reg[i]        <= 1'b0;
                    abort_pend_reg[i] <= 1'b0;
                    if (mode_reg != MODE_LEGACY) begin
                        sent_reg[i] <= 1'b1;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Scheduler

    logic [NUM_BUFFERS-1:0] pending;
    logic                   pick_any;
    logic [1:0]             pick_idx;

    assign pending = req_reg & ~abort_pend_reg;

    always_comb begin
        logic [1:0] best;
        best     = 2'h0;
        pick_any = 1'b0;
        pick_idx = 2'h0;
        // Ascending scan with >= lets the higher index win a tie
        for (int n = 0; n < NUM_BUFFERS; n++) begin
            if (pending[n] && (!pick_any || prio_reg[n] >= best)) begin
                best     = prio_reg[n];
                pick_idx = 2'(n);
                pick_any = 1'b1;
            end
        end
    end

    // Priority is never folded into the identifier
    function automatic frame_t build_frame(input logic [1:0] b);
        frame_t f;
        f.extended = sidl_reg[b][SIDL_EXT_BIT];
        if (f.extended) begin
            f.ident = {sidh_reg[b], sidl_reg[b][7:5], sidl_reg[b][1:0],
                       eidh_reg[b], eidl_reg[b]};
        end else begin
            f.ident = {18'h0_0000, sidh_reg[b], sidl_reg[b][7:5]};
        end
        f.byte_count = (len_reg[b] > MAX_BYTES) ? MAX_BYTES : len_reg[b];
        for (int m = 0; m < NUM_DATA; m++) begin
            f.payload[m*8 +: 8] = data_reg[b][m];
        end
        f.buf_idx = b;
        return f;
    endfunction : build_frame

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg  <= ST_IDLE;
            active_reg <= 2'h0;
            frame_reg  <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (pick_any) begin
                        active_reg <= pick_idx;
                        frame_reg  <= build_frame(pick_idx);
                        state_reg  <= ST_OFFER;
                    end
                end
                ST_OFFER: begin
                    // Offer withdrawn if software aborted it meanwhile
                    if (!req_reg[active_reg]) begin
                        state_reg <= ST_IDLE;
                    end else if (frame_ready) begin
                        state_reg <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    // Lost arbitration or error ends the attempt; request stays for retry
                    if (tx_event.done || tx_event.lost_arb || tx_event.bus_err || tx_event.abort_ack) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    assign frame_valid = (state_reg == ST_OFFER) && req_reg[active_reg];
    assign frame       = frame_reg;
    assign abort_req   = in_send && abort_pend_reg[active_reg];

endmodule : can_transmit_buffer_set

`default_nettype wire

// file: dv/can_engine_model.sv
// Behavioural bit engine facing the transmit buffer set
`timescale 1ns/100ps
`default_nettype none

module can_engine_model import can_tx_buffer_pkg::*; (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Frame handshake
    input  wire logic       frame_valid,
    output logic            frame_ready,
    input  wire logic       abort_req,
    output tx_event_t       tx_event,
    // Behaviour chosen by the bench: 0 done, 1 lost, 2 bus error, 3 never ends
    input  wire logic [1:0] outcome,
    input  wire logic [3:0] lag
);
    logic       sending;
    logic [3:0] cnt;

    ////////////////////////////////////////////////////////////
    // Events are single pulses, so the default is all quiet
    always_ff @(posedge clk) begin
        tx_event    <= '0;
        frame_ready <= 1'b0;
        cnt         <= cnt + 4'h1;
        if (sys_rst) begin
            sending <= 1'b0;
            cnt     <= 4'h0;
        end else if (!sending) begin
            if (!frame_valid)
                cnt <= 4'h0;
            else if (frame_ready) begin
                sending <= 1'b1;
                cnt     <= 4'h0;
            end else if (cnt >= lag)
                frame_ready <= 1'b1;
        end else if (abort_req) begin
            tx_event.abort_ack <= 1'b1;
            sending            <= 1'b0;
        end else if (cnt >= lag && outcome != 2'h3) begin
            tx_event.done     <= outcome == 2'h0;
            tx_event.lost_arb <= outcome == 2'h1;
            tx_event.bus_err  <= outcome == 2'h2;
            sending           <= 1'b0;
        end
    end
endmodule : can_engine_model
`default_nettype wire

// file: dv/can_tx_buffer_asserts.sv
// Port-level assertions for the CAN transmit buffer set
`timescale 1ns/100ps
`default_nettype none

module can_tx_buffer_asserts import can_tx_buffer_pkg::*; (
    // Clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Engine side
    input wire logic        frame_valid,
    input wire logic        frame_ready,
    input wire frame_t      frame,
    input wire logic        abort_req,
    input wire tx_event_t   tx_event
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////
    logic rd_setup;
    assign rd_setup = psel && !penable && !pwrite && paddr < OFS_MODE && paddr[1:0] == 2'h0;

    // Software writes are excluded, an abort may legally pull the offer
    sequence offer_waits;
        frame_valid && !frame_ready && !(psel && pwrite);
    endsequence
    sequence accepted;
        frame_valid && frame_ready;
    endsequence

    a_ctl_spare_zero: assert property (
        rd_setup && paddr[5:0] == OFS_CONTROL |=> prdata[2] == 1'b0 && prdata[31:8] == 24'h0)
        else $error("control spare bits read nonzero");
    a_idlow_spare_zero: assert property (
        rd_setup && paddr[5:0] == OFS_SID_LOW |=> (prdata & ~32'(SIDL_IMPL_MASK)) == 32'h0)
        else $error("id low spare bits read nonzero");
    a_bad_addr: assert property (
        psel && !penable && paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0)
        else $error("unaligned access not refused");
    a_offer_holds: assert property (offer_waits |=> frame_valid)
        else $error("offer dropped without accept");
    a_offer_stable: assert property (offer_waits |=> $stable(frame))
        else $error("offered frame changed");
    a_accept_leaves: assert property (accepted |=> !frame_valid)
        else $error("offer kept after accept");
    a_abort_scope: assert property (abort_req |-> !frame_valid)
        else $error("abort raised during offer");
    a_abort_holds: assert property (abort_req && tx_event == '0 |=> abort_req)
        else $error("abort dropped before engine answer");
    a_abort_ends: assert property (abort_req && tx_event != '0 |=> !abort_req)
        else $error("abort kept after engine answer");
    a_count_limit: assert property (frame_valid |-> frame.byte_count <= MAX_BYTES)
        else $error("byte count above eight");
    a_reset_quiet: assert property ($fell(sys_rst) |-> !frame_valid && !abort_req)
        else $error("engine side active after reset");
endmodule : can_tx_buffer_asserts

bind can_transmit_buffer_set can_tx_buffer_asserts can_tx_buffer_asserts_inst (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .frame_valid(frame_valid),
    .frame_ready(frame_ready), .frame(frame), .abort_req(abort_req), .tx_event(tx_event)
);
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the CAN transmit buffer set
`timescale 1ns/100ps
`default_nettype none

module testbench import can_tx_buffer_pkg::*; ();
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        frame_valid;
    logic        frame_ready;
    logic        abort_req;
    frame_t      frame;
    tx_event_t   tx_event;
    logic [1:0]  outcome = 2'h0;
    logic [3:0]  lag = 4'h2;
    logic [31:0] lf = 32'h0001481B;
    int          error_cnt = 0;
    int          n_checks = 0;
    logic [32:0] qr[$];
    frame_t      qf[$];
    frame_t      ef[3];

    always #50 clk = ~clk;

    can_transmit_buffer_set can_transmit_buffer_set_inst (
        .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .frame_valid(frame_valid), .frame_ready(frame_ready), .frame(frame),
        .abort_req(abort_req), .tx_event(tx_event));
    can_engine_model can_engine_model_inst (
        .clk(clk), .sys_rst(sys_rst), .frame_valid(frame_valid), .frame_ready(frame_ready),
        .abort_req(abort_req), .tx_event(tx_event), .outcome(outcome), .lag(lag));

    ////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        lf = lf[0] ? (lf >> 1) ^ 32'h80200003 : lf >> 1;
        return lf[7:0];
    endfunction : rnd
    function automatic logic [7:0] ad(input int n, input logic [5:0] o);
        return 8'(n) * BUF_STRIDE + {2'h0, o};
    endfunction : ad
    task automatic end_sim();
        if (error_cnt == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim
    task automatic cmp_rd(input logic [32:0] e, input logic [32:0] s);
        n_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] read exp %h got %h", e, s);
        end
    endtask : cmp_rd
    task automatic cmp_fr(input frame_t e, input frame_t s);
        logic [28:0] m;
        m = e.extended ? 29'h1FFFFFFF : 29'h000007FF;
        n_checks++;
        if ({s.extended, s.ident & m, s.byte_count, s.payload, s.buf_idx} !==
            {e.extended, e.ident & m, e.byte_count, e.payload, e.buf_idx}) begin
            error_cnt++;
            $display("[FAIL] frame exp %h got %h", e, s);
        end
    endtask : cmp_fr
    // Idle cycle after each transfer keeps one assignment per signal per step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic err = 1'b0);
        qr.push_back({err, 24'h0, e});
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic go(input int n, input logic [7:0] c);
        qf.push_back(ef[n]);
        wr(ad(n, OFS_CONTROL), c);
    endtask : go
    task automatic wait_ev();
        do @(negedge clk); while (tx_event === '0);
        @(posedge clk);
    endtask : wait_ev
    task automatic wait_acc();
        do @(negedge clk); while (!(frame_valid && frame_ready));
        @(posedge clk);
    endtask : wait_acc
    task automatic load(input int n, input logic x, input logic [3:0] len);
        logic [7:0] b[4];
        for (int i = 0; i < 4; i++) b[i] = rnd();
        b[1][3] = x;
        ef[n] = '0;
        ef[n].extended = x;
        ef[n].ident = x ? {b[0], b[1][7:5], b[1][1:0], b[2], b[3]} : {18'h0_0000, b[0], b[1][7:5]};
        ef[n].byte_count = len > MAX_BYTES ? MAX_BYTES : len;
        ef[n].buf_idx = 2'(n);
        for (int i = 0; i < 4; i++) wr(ad(n, OFS_SID_HIGH + 6'(4 * i)), b[i]);
        wr(ad(n, OFS_LENGTH), {4'h0, len});
        for (int m = 0; m < 8; m++) begin
            ef[n].payload[8*m +: 8] = rnd();
            wr(ad(n, OFS_DATA + 6'(4 * m)), ef[n].payload[8*m +: 8]);
        end
        rd(ad(n, OFS_SID_LOW), b[1] & SIDL_IMPL_MASK);
        rd(ad(n, OFS_DATA + 6'h1C), ef[n].payload[63:56]);
    endtask : load

    ////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite)
            cmp_rd(qr.pop_front(), {pslverr, prdata});
        if (frame_valid && frame_ready)
            cmp_fr(qf.size() > 0 ? qf.pop_front() : frame_t'(0), frame);
    end

    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        end_sim();
    end

    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        for (int n = 0; n < 3; n++) rd(ad(n, OFS_CONTROL), 8'h00);
        rd(8'hC8, 8'h00, 1'b1);
        rd(8'h41, 8'h00, 1'b1);
        load(0, 1'b0, 4'h8);
        load(1, 1'b1, 4'hF);
        load(2, 1'b0, 4'h0);
        go(2, 8'h0A);
        wait_ev();
        rd(ad(2, OFS_CONTROL), 8'h02);
        for (int m = 3; m > 0; m--) begin
            wr(OFS_MODE, 8'(m));
            rd(OFS_MODE, m == 3 ? 8'h00 : 8'(m));
        end
        lag <= 4'h4;
        // Lost arbitration and bus error retry until a clean send
        for (int o = 1; o < 3; o++) begin
            outcome <= 2'(o);
            qf.push_back(ef[0]);
            go(0, 8'h09);
            wait_ev();
            outcome <= 2'h0;
            rd(ad(0, OFS_CONTROL), o == 1 ? 8'h29 : 8'h19);
            wait_ev();
            rd(ad(0, OFS_CONTROL), o == 1 ? 8'hA1 : 8'h91);
        end
        outcome <= 2'h3;
        go(0, 8'h0B);
        wait_acc();
        wr(ad(0, OFS_SID_HIGH), ~ef[0].ident[10:3]);
        wr(ad(1, OFS_CONTROL), 8'h08);
        wr(ad(1, OFS_CONTROL), 8'h00);
        rd(ad(1, OFS_CONTROL), 8'h40);
        wr(ad(0, OFS_CONTROL), 8'h03);
        wait_ev();
        outcome <= 2'h0;
        lag <= 4'hF;
        rd(ad(0, OFS_CONTROL), 8'h43);
        rd(ad(0, OFS_SID_HIGH), ef[0].ident[10:3]);
        go(0, 8'h08);
        wait_acc();
        qf.push_back(ef[1]);
        qf.push_back(ef[2]);
        wr(ad(2, OFS_CONTROL), 8'h09);
        wr(ad(1, OFS_CONTROL), 8'h0B);
        while (qf.size() > 0) @(posedge clk);
        go(1, 8'h08);
        wait_acc();
        qf.push_back(ef[2]);
        qf.push_back(ef[0]);
        wr(ad(0, OFS_CONTROL), 8'h0A);
        wr(ad(2, OFS_CONTROL), 8'h0A);
        while (qf.size() > 0) @(posedge clk);
        end_sim();
    end
endmodule : testbench
`default_nettype wire
